// ---- shared/frd_pkg.sv ----
// Purpose: constants for the flash read-path interface
// Assumes: one clock, synchronous active-high reset
// Notes: bit positions index the read configuration word
package frd_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int PAGE_WORDS = 8;
    localparam int PAGE_SEL_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int CFG_W = 16;
    localparam int BIT_NOWRAP = 3;
    localparam int BIT_CLK_EDGE = 6;
    localparam int BIT_VALID_TIMING = 8;
    localparam int BIT_READ_MODE = 15;
    localparam logic [1:0] BLEN_4 = 2'h1;
    localparam logic [1:0] BLEN_8 = 2'h2;
    localparam logic [1:0] BLEN_CONT = 2'h3;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam int LATENCY_CYC = 2;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h8000;
    typedef enum logic [1:0] {REG_ARRAY, REG_QUERY, REG_STATUS, REG_ID} frd_region_t;
endpackage

// ---- rtl/frd_fifo.sv ----
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: full and empty are exact
`timescale 1ns/1ns
module frd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic push, pop;

    assign in_ready_o = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_r != rd_r;
    assign out_data_o = mem_r[rd_r[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb
    begin
        mem_nxt = mem_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        if (push)
        begin
            mem_nxt[wr_r[AW-1:0]] = in_data_i;
            wr_nxt = wr_r + 1'b1;
        end
        if (pop)
        begin
            rd_nxt = rd_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        mem_r <= mem_nxt;
        if (reset_i)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end
endmodule

// ---- rtl/frd_read_if.sv ----
// Purpose: read-path interface of a parallel flash device
// Assumes: bus pins arrive asynchronously and are synchronised here
// Notes: array contents come from a user-side read port that answers each request with array_valid_i
`timescale 1ns/1ns
module frd_read_if #(
    parameter int ADDR_W = frd_pkg::ADDR_W,
    parameter int DATA_W = frd_pkg::DATA_W,
    parameter int FIFO_DEPTH = frd_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic chip_select_n_i,
    input wire logic output_enable_n_i,
    input wire logic address_valid_n_i,
    input wire logic burst_clk_i,
    input wire logic [ADDR_W-1:0] addr_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic wait_n_o,
    output logic wait_oe_o,
    input wire logic [frd_pkg::CFG_W-1:0] read_config_register_i,
    input wire logic read_config_load_i,
    input wire logic [1:0] burst_length_i,
    input wire logic [7:0] command_port_i,
    input wire logic command_valid_i,
    input wire logic status_select_i,
    input wire logic id_select_i,
    output logic [frd_pkg::CFG_W-1:0] read_config_o,
    output logic burst_mode_o,
    output logic array_rd_o,
    output logic [ADDR_W-1:0] array_addr_o,
    input wire logic [DATA_W-1:0] array_data_i,
    input wire logic array_valid_i,
    output logic array_ready_o,
    input wire logic [DATA_W-1:0] alt_data_i
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [3:0] sy1_r, sy2_r, syp_r;
    logic [ADDR_W-1:0] ad1_r, ad2_r;
    always_ff @(posedge sys_clk_i)
    begin
        sy1_r <= {burst_clk_i, address_valid_n_i, output_enable_n_i, chip_select_n_i};
        sy2_r <= sy1_r;
        syp_r <= sy2_r;
        ad1_r <= addr_i;
        ad2_r <= ad1_r;
    end
    logic cs_n, oe_n, adv_n, clk_s;
    assign {clk_s, adv_n, oe_n, cs_n} = sy2_r;
    logic adv_rise, clk_rise, clk_fall;
    assign adv_rise = adv_n && !syp_r[2];
    assign clk_rise = clk_s && !syp_r[3];
    assign clk_fall = !clk_s && syp_r[3];

    ////////////////////////////////////////////////////////////////////////////
    // configuration and command state
    logic [frd_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
    logic query_r, query_nxt;
    always_comb
    begin
        cfg_nxt = cfg_r;
        query_nxt = query_r;
        if (read_config_load_i)
        begin
            cfg_nxt = read_config_register_i;
        end
        if (command_valid_i)
        begin
            query_nxt = (command_port_i == frd_pkg::CMD_QUERY);
        end
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cfg_r <= frd_pkg::CFG_RESET;
            query_r <= 1'b0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            query_r <= query_nxt;
        end
    end
    logic async_mode, nowrap, edge_fall, early_flag;
    assign async_mode = cfg_r[frd_pkg::BIT_READ_MODE];
    assign nowrap = cfg_r[frd_pkg::BIT_NOWRAP];
    assign edge_fall = cfg_r[frd_pkg::BIT_CLK_EDGE];
    assign early_flag = cfg_r[frd_pkg::BIT_VALID_TIMING];
    assign read_config_o = cfg_r;
    assign burst_mode_o = !async_mode;
    frd_pkg::frd_region_t region;
    always_comb
    begin
        if (query_r)
            region = frd_pkg::REG_QUERY;
        else if (status_select_i)
            region = frd_pkg::REG_STATUS;
        else if (id_select_i)
            region = frd_pkg::REG_ID;
        else
            region = frd_pkg::REG_ARRAY;
    end
    logic single_only;
    assign single_only = region != frd_pkg::REG_ARRAY;
    logic act_edge;
    assign act_edge = edge_fall ? clk_fall : clk_rise;

    ////////////////////////////////////////////////////////////////////////////
    // read sequencer
    typedef enum {ST_IDLE, ST_PAGE, ST_ASYNC, ST_BURST, ST_SYNC} frd_state_t;
    frd_state_t st_r, st_nxt;
    logic [ADDR_W-1:0] ptr_r, ptr_nxt, base_r, base_nxt;
    logic [3:0] fill_r, fill_nxt;
    logic [DATA_W-1:0] page_r [frd_pkg::PAGE_WORDS];
    logic [DATA_W-1:0] page_nxt [frd_pkg::PAGE_WORDS];
    logic [DATA_W-1:0] dout_r, dout_nxt;
    logic [1:0] lat_r, lat_nxt;
    logic [1:0] blen_r, blen_nxt;
    logic pend_r, pend_nxt;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [DATA_W-1:0] fifo_out_data;
    logic sel, latch_ev;
    assign sel = !cs_n;
    assign latch_ev = adv_rise || (!adv_n && act_edge);

    logic [ADDR_W-1:0] next_ptr;
    always_comb
    begin
        next_ptr = ptr_r + 1'b1;
        if (!nowrap && blen_r == frd_pkg::BLEN_4)
            next_ptr = {ptr_r[ADDR_W-1:2], 2'(ptr_r[1:0] + 2'h1)};
        else if (!nowrap && blen_r == frd_pkg::BLEN_8)
            next_ptr = {ptr_r[ADDR_W-1:3], 3'(ptr_r[2:0] + 3'h1)};
    end

    always_comb
    begin
        st_nxt = st_r;
        ptr_nxt = ptr_r;
        base_nxt = base_r;
        fill_nxt = fill_r;
        page_nxt = page_r;
        dout_nxt = dout_r;
        lat_nxt = lat_r;
        blen_nxt = blen_r;
        pend_nxt = pend_r;
        fifo_pop = 1'b0;
        array_rd_o = 1'b0;
        case (st_r)
            ST_IDLE:
            begin
                if (pend_r)
                    st_nxt = ST_IDLE; // wait out a stray reply
                else if (sel && async_mode && !adv_n && !single_only)
                begin
                    base_nxt = {ad2_r[ADDR_W-1:3], 3'h0};
                    ptr_nxt = {ad2_r[ADDR_W-1:3], 3'h0};
                    fill_nxt = 4'h0;
                    st_nxt = ST_PAGE;
                end
                else if (sel && async_mode && adv_rise)
                begin
                    ptr_nxt = ad2_r;
                    fill_nxt = 4'h0;
                    st_nxt = ST_ASYNC;
                end
                else if (sel && !async_mode && latch_ev)
                begin
                    ptr_nxt = ad2_r;
                    fill_nxt = 4'h0;
                    blen_nxt = burst_length_i;
                    lat_nxt = 2'(frd_pkg::LATENCY_CYC);
                    st_nxt = (single_only || burst_length_i == 2'h0) ? ST_SYNC : ST_BURST;
                end
            end
            ST_PAGE:
            begin
                if (fill_r < 4'(frd_pkg::PAGE_WORDS))
                begin
                    array_rd_o = !pend_r; // one request in flight
                    if (array_valid_i && pend_r)
                    begin
                        page_nxt[fill_r[2:0]] = array_data_i;
                        fill_nxt = fill_r + 4'h1;
                        ptr_nxt = ptr_r + 1'b1;
                    end
                end
                else
                begin
                    dout_nxt = page_r[ad2_r[frd_pkg::PAGE_SEL_W-1:0]];
                end
                if (ad2_r[ADDR_W-1:3] != base_r[ADDR_W-1:3] && fill_r == 4'h8)
                    st_nxt = ST_IDLE;
                if (adv_rise)
                begin
                    ptr_nxt = ad2_r;
                    fill_nxt = 4'h0;
                    st_nxt = ST_ASYNC;
                end
                if (cs_n)
                    st_nxt = ST_IDLE;
            end
            ST_ASYNC, ST_SYNC:
            begin
                array_rd_o = !pend_r && fill_r == 4'h0;
                if (array_rd_o)
                    fill_nxt = 4'h1;
                if (array_valid_i && fill_r != 4'h0)
                begin
                    dout_nxt = single_only ? alt_data_i : array_data_i;
                    st_nxt = ST_IDLE;
                end
                if (cs_n)
                    st_nxt = ST_IDLE;
            end
            ST_BURST:
            begin
                array_rd_o = fifo_in_ready && !pend_r;
                if (array_valid_i && fifo_in_ready)
                    ptr_nxt = next_ptr;
                if (lat_r != 2'h0 && act_edge)
                    lat_nxt = lat_r - 2'h1;
                if (lat_r == 2'h0 && act_edge && fifo_out_valid)
                begin
                    fifo_pop = 1'b1;
                    dout_nxt = fifo_out_data;
                end
                if (cs_n || adv_rise)
                    st_nxt = ST_IDLE;
            end
            default:
                st_nxt = ST_IDLE;
        endcase
        if (array_valid_i)
            pend_nxt = 1'b0;
        if (array_rd_o)
            pend_nxt = 1'b1;
    end
    assign array_addr_o = ptr_r;
    assign array_ready_o = (st_r == ST_BURST) ? fifo_in_ready : 1'b1;

    frd_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i || st_r != ST_BURST),
        .in_valid_i(array_valid_i && st_r == ST_BURST),
        .in_ready_o(fifo_in_ready),
        .in_data_i(array_data_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // validity flag
    logic wait_r, wait_nxt;
    logic data_ok, data_ok_ahead;
    assign data_ok = fifo_out_valid;
    assign data_ok_ahead = fifo_out_valid && !(fifo_pop && !fifo_in_ready && !array_valid_i);
    always_comb
    begin
        wait_nxt = 1'b1;
        if (!async_mode && st_r == ST_BURST && lat_r == 2'h0 && (nowrap || blen_r == frd_pkg::BLEN_CONT))
            wait_nxt = early_flag ? data_ok_ahead : data_ok;
        if (async_mode)
            wait_nxt = 1'b1;
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            st_r <= ST_IDLE;
            ptr_r <= '0;
            base_r <= '0;
            fill_r <= 4'h0;
            dout_r <= '0;
            lat_r <= 2'h0;
            blen_r <= 2'h0;
            wait_r <= 1'b1;
            pend_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            ptr_r <= ptr_nxt;
            base_r <= base_nxt;
            fill_r <= fill_nxt;
            dout_r <= dout_nxt;
            lat_r <= lat_nxt;
            blen_r <= blen_nxt;
            wait_r <= wait_nxt;
            pend_r <= pend_nxt;
        end
        page_r <= page_nxt;
    end
    assign data_o = dout_r;
    assign data_oe_o = !cs_n && !oe_n;
    assign wait_oe_o = !cs_n && !oe_n;
    assign wait_n_o = wait_oe_o ? wait_r : 1'b1;
endmodule

// ---- testbench/frd_read_if_chk.sv ----
// Purpose: port assertions for the flash read interface
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind below
`timescale 1ns/1ns
module frd_read_if_chk (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic chip_select_n_i,
    input wire logic address_valid_n_i,
    input wire logic read_config_load_i,
    input wire logic [frd_pkg::CFG_W-1:0] read_config_register_i,
    input wire logic [frd_pkg::CFG_W-1:0] read_config_o,
    input wire logic burst_mode_o,
    input wire logic data_oe_o,
    input wire logic wait_n_o,
    input wire logic wait_oe_o,
    input wire logic array_rd_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    property p_reset_mode; $fell(reset_i) |-> read_config_o == frd_pkg::CFG_RESET; endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("config not async after reset");
    property p_load; read_config_load_i |=> read_config_o == $past(read_config_register_i); endproperty
    a_load: assert property (p_load) else $error("config word not loaded");
    property p_mode; burst_mode_o == !read_config_o[frd_pkg::BIT_READ_MODE]; endproperty
    a_mode: assert property (p_mode) else $error("mode output disagrees with config");
    property p_async_flag;
        read_config_o[frd_pkg::BIT_READ_MODE] && $past(read_config_o[frd_pkg::BIT_READ_MODE]) |-> wait_n_o;
    endproperty
    a_async_flag: assert property (p_async_flag) else $error("flag low in async mode");
    property p_pullup; !wait_oe_o |-> wait_n_o; endproperty
    a_pullup: assert property (p_pullup) else $error("flag low while released");
    property p_oe_pair; data_oe_o == wait_oe_o; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("flag and data enables differ");
    property p_cs_off; chip_select_n_i [*4] |-> !wait_oe_o; endproperty
    a_cs_off: assert property (p_cs_off) else $error("flag driven while deselected");
    property p_flag_low; !wait_n_o |-> burst_mode_o && wait_oe_o; endproperty
    a_flag_low: assert property (p_flag_low) else $error("flag low outside burst");
    property p_adv_read;
        read_config_o[frd_pkg::BIT_READ_MODE] && !chip_select_n_i && $rose(address_valid_n_i) |-> ##[1:8] array_rd_o;
    endproperty
    a_adv_read: assert property (p_adv_read) else $error("no array read after address latch");
    c_burst: cover property (burst_mode_o && !chip_select_n_i);
    c_flag: cover property (!wait_n_o);
    c_load: cover property (read_config_load_i);
endmodule
bind frd_read_if frd_read_if_chk chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .chip_select_n_i(chip_select_n_i), .address_valid_n_i(address_valid_n_i),
    .read_config_load_i(read_config_load_i), .read_config_register_i(read_config_register_i),
    .read_config_o(read_config_o), .burst_mode_o(burst_mode_o), .data_oe_o(data_oe_o),
    .wait_n_o(wait_n_o), .wait_oe_o(wait_oe_o), .array_rd_o(array_rd_o));

// ---- testbench/frd_host_model.sv ----
// Purpose: host pin driver and array storage model
// Assumes: pins change 1 ns after the clock edge
// Notes: released address lines show the inverse of the last value
`timescale 1ns/1ns
module frd_host_model (
    input wire logic sys_clk_i,
    input wire logic array_rd_i,
    input wire logic [20:0] array_addr_i,
    output logic cs_n_o,
    output logic oe_n_o,
    output logic adv_n_o,
    output logic bclk_o,
    output logic [20:0] addr_o,
    output logic [15:0] array_data_o,
    output logic array_valid_o
);
    initial
    begin
        cs_n_o = 1'b1;
        oe_n_o = 1'b1;
        adv_n_o = 1'b1;
        bclk_o = 1'b0;
        addr_o = 21'h00_0000;
        array_data_o = 16'h0000;
        array_valid_o = 1'b0;
    end
    always @(posedge sys_clk_i)
    begin
        array_valid_o <= array_rd_i;
        array_data_o <= array_rd_i ? (array_addr_i[15:0] ^ 16'h5a5a) : ~array_data_o;
    end
    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task open(input logic [20:0] a);
        cs_n_o = 1'b0;
        oe_n_o = 1'b0;
        adv_n_o = 1'b0;
        addr_o = a;
        cyc(16);
    endtask
    task close;
        cs_n_o = 1'b1;
        oe_n_o = 1'b1;
        adv_n_o = 1'b1;
        addr_o = ~addr_o;
        cyc(4);
    endtask
    task page_word(input logic [2:0] w);
        addr_o[2:0] = w;
        cyc(6);
    endtask
    task latch(input logic [20:0] a);
        open(a);
        adv_n_o = 1'b1;
        cyc(12);
    endtask
    task clk_edge;
        bclk_o = 1'b1;
        cyc(6);
        bclk_o = 1'b0;
        cyc(6);
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Purpose: directed checks of the flash read interface
// Assumes: array word equals address xor 5a5a
// Notes: burst clock idles low between frames
`timescale 1ns/1ns
module testbench;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] cfg = 16'h8000;
    logic cfg_ld = 1'b0;
    logic [1:0] blen = 2'h0;
    logic [7:0] cmd = 8'h00;
    logic cmd_v = 1'b0;
    logic [15:0] alt = 16'hc3c3;
    logic stat_sel = 1'b0;
    logic id_sel = 1'b0;
    logic cs_n, oe_n, adv_n, bclk, arr_v, d_oe, wt_n, wt_oe, bmode, ard, ardy;
    logic [20:0] addr, aaddr;
    logic [15:0] dq, adata, rcfg;
    int miscompares = 0;
    int check_count = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    frd_read_if dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .chip_select_n_i(cs_n),
        .output_enable_n_i(oe_n), .address_valid_n_i(adv_n), .burst_clk_i(bclk), .addr_i(addr),
        .data_o(dq), .data_oe_o(d_oe), .wait_n_o(wt_n), .wait_oe_o(wt_oe), .read_config_register_i(cfg),
        .read_config_load_i(cfg_ld), .burst_length_i(blen), .command_port_i(cmd), .command_valid_i(cmd_v),
        .status_select_i(stat_sel), .id_select_i(id_sel), .read_config_o(rcfg), .burst_mode_o(bmode),
        .array_rd_o(ard), .array_addr_o(aaddr), .array_data_i(adata), .array_valid_i(arr_v),
        .array_ready_o(ardy), .alt_data_i(alt));
    frd_host_model host (.sys_clk_i(sys_clk_i), .array_rd_i(ard), .array_addr_i(aaddr), .cs_n_o(cs_n),
        .oe_n_o(oe_n), .adv_n_o(adv_n), .bclk_o(bclk), .addr_o(addr), .array_data_o(adata),
        .array_valid_o(arr_v));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic command(logic [7:0] c);
        cmd = c;
        cmd_v = 1'b1;
        host.cyc(1);
        cmd_v = 1'b0;
        host.cyc(2);
    endtask
    task automatic load_cfg(logic [15:0] v);
        cfg = v;
        cfg_ld = 1'b1;
        host.cyc(1);
        cfg_ld = 1'b0;
        host.cyc(2);
    endtask
    task automatic burst(logic [20:0] a, int n);
        logic [20:0] e;
        host.latch(a);
        host.clk_edge();
        host.clk_edge();
        for (int k = 0; k < n; k++)
        begin
            host.clk_edge();
            e = a + 21'(k);
            if (blen == frd_pkg::BLEN_4 && !cfg[frd_pkg::BIT_NOWRAP])
                e = {a[20:2], a[1:0] + 2'(k)};
            if (blen == frd_pkg::BLEN_8 && !cfg[frd_pkg::BIT_NOWRAP])
                e = {a[20:3], a[2:0] + 3'(k)};
            chk("burst", dq, e[15:0] ^ 16'h5a5a);
            chk("burst flag", wt_n, 1);
        end
        host.close();
    endtask
    initial
    begin
        #100000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        #1 reset_i = 1'b0;
        host.cyc(4);
        chk("config", rcfg, 16'h8000);
        chk("mode", bmode, 0);
        host.open(21'h00_0120);
        for (int w = 7; w >= 0; w--)
        begin
            host.page_word(3'(w));
            chk("page", dq, 16'h0120 + 16'(w) ^ 16'h5a5a);
            chk("flag", wt_n, 1);
            chk("enable", wt_oe, 1);
        end
        host.close();
        host.latch(21'h00_0345);
        chk("single", dq, 16'h0345 ^ 16'h5a5a);
        host.close();
        command(frd_pkg::CMD_QUERY);
        host.latch(21'h00_0010);
        chk("query", dq, alt);
        host.close();
        command(frd_pkg::CMD_READ_ARRAY);
        alt = 16'h3c3c;
        stat_sel = 1'b1;
        host.latch(21'h00_0011);
        chk("status", dq, 16'h3c3c);
        host.close();
        stat_sel = 1'b0;
        load_cfg(16'h0000);
        chk("mode", bmode, 1);
        blen = frd_pkg::BLEN_4;
        burst(21'h00_0202, 4);
        blen = frd_pkg::BLEN_8;
        burst(21'h00_020a, 8);
        blen = frd_pkg::BLEN_CONT;
        burst(21'h00_030e, 10);
        id_sel = 1'b1;
        host.latch(21'h00_0040);
        chk("id burst", dq, 16'h3c3c);
        host.close();
        id_sel = 1'b0;
        blen = 2'h0;
        for (int j = 0; j < 2; j++)
        begin
            host.latch(21'h00_0400 + 21'(j));
            chk("sync single", dq, 16'h0400 + 16'(j) ^ 16'h5a5a);
            host.close();
        end
        load_cfg(16'h0148);
        blen = frd_pkg::BLEN_4;
        burst(21'h00_0502, 4);
        chk("release", wt_oe, 0);
        chk("pullup", wt_n, 1);
        reset_i = 1'b1;
        host.cyc(2);
        reset_i = 1'b0;
        host.cyc(4);
        chk("config", rcfg, 16'h8000);
        chk("mode", bmode, 0);
        end_sim();
    end
endmodule
